/* File: src/acc_defines.vh */
// Constants for the converter clocking and conversion sequencer.
// Included by every design file of the block; definitions only.
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

// Divider-select codes and their prescaling ratios
`define ACC_DIV_SEL_RESET  2'h3
`define ACC_DIV_CODE_2     2'h0
`define ACC_DIV_CODE_3     2'h1
`define ACC_DIV_CODE_4     2'h2
`define ACC_RATIO_2        6'h02
`define ACC_RATIO_3        6'h03
`define ACC_RATIO_4        6'h04
`define ACC_RATIO_32       6'h20

// Phase lengths in analog-internal clock periods
`define ACC_SYNC_TICKS     9'h001
`define ACC_SAMPLE_BASE    9'h002
`define ACC_WRITE_TICKS    9'h003

// Resolutions and widths
`define ACC_BITS_HI        4'ha
`define ACC_BITS_LO        4'h8
`define ACC_CHANNELS       8
`define ACC_RESULT_REGS    4
`define ACC_SOURCES        2

// Sequencer states
`define ACC_ST_IDLE        3'h0
`define ACC_ST_SYNC        3'h1
`define ACC_ST_SAMPLE      3'h2
`define ACC_ST_CONV        3'h3
`define ACC_ST_WRITE       3'h4

`endif

/* File: src/acc_prescaler.v */
// Prescaler that turns the module clock into one-cycle enable pulses,
// one per analog-internal clock period. Assumes restart is a same-clock
// strobe from the sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.vh"

module acc_prescaler (
   input  wire       core_clk,
   input  wire       rst,
   input  wire       analog_enable,
   input  wire       restart,
   input  wire [1:0] conv_clock_div_sel,
   output wire       tick
);

   reg [5:0] count;

   function [5:0] ratio_of;
      input [1:0] sel;
      begin
         case (sel)
            `ACC_DIV_CODE_2: ratio_of = `ACC_RATIO_2;
            `ACC_DIV_CODE_3: ratio_of = `ACC_RATIO_3;
            `ACC_DIV_CODE_4: ratio_of = `ACC_RATIO_4;
            default:         ratio_of = `ACC_RATIO_32;
         endcase
      end
   endfunction

   assign tick = analog_enable & ~restart &
                 (count == ratio_of(conv_clock_div_sel) - 6'h01);

   always @(posedge core_clk) begin
      if (rst || !analog_enable || restart || tick) begin
         count <= 6'h00;
      end else begin
         count <= count + 6'h01;
      end
   end

endmodule
`default_nettype wire

/* File: src/acc_result_store.v */
// Four shared result registers with optional two-result accumulation and
// an unread flag per register. Assumes write and read strobes are
// one-cycle pulses on core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.vh"

module acc_result_store (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        wr,
   input  wire [1:0]  wr_sel,
   input  wire [9:0]  wr_data,
   input  wire [3:0]  accum_en,
   input  wire        rd_strobe,
   input  wire [1:0]  rd_sel,
   output reg  [10:0] rd_data,
   output reg  [3:0]  unread,
   output reg  [3:0]  result_irq
);

   reg [10:0] value [0:3];
   reg [3:0]  accum_half;
   integer    i;

   always @(posedge core_clk) begin
      if (rst) begin
         for (i = 0; i < 4; i = i + 1) begin
            value[i] <= 11'h000;
         end
         accum_half <= 4'h0;
         unread     <= 4'h0;
         result_irq <= 4'h0;
         rd_data    <= 11'h000;
      end else begin
         result_irq <= 4'h0;
         if (rd_strobe) begin
            rd_data        <= value[rd_sel];
            unread[rd_sel] <= 1'b0;
         end
         if (wr) begin
            // second result adds to the first
            if (accum_en[wr_sel] && accum_half[wr_sel]) begin
               value[wr_sel] <= value[wr_sel] + {1'b0, wr_data};
               accum_half[wr_sel] <= 1'b0;
            end else begin
               value[wr_sel] <= {1'b0, wr_data};
               accum_half[wr_sel] <= accum_en[wr_sel];
            end
            // A write in the same cycle as a read leaves the flag set
            unread[wr_sel] <= 1'b1;
            result_irq[wr_sel] <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

/* File: src/acc_conv_ctrl.v */
// Conversion sequencer for a 10-bit successive-approximation converter:
// arbitration of two request sources, sync/sample/convert/write phases,
// status flags and interrupt pulses. Assumes the comparator output of the
// analog stage is produced on core_clk and is settled at each tick.
// A running conversion is cancelled only by dropping analog_enable: a higher-priority request
// waits for the idle state.
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.vh"

module acc_conv_ctrl (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        analog_enable,
   input  wire [1:0]  conv_clock_div_sel,
   input  wire [7:0]  sample_time_ext,
   input  wire        res_8bit,
   input  wire        req_pend0,
   input  wire [2:0]  req_chan0,
   input  wire [1:0]  req_prio0,
   input  wire        req_pend1,
   input  wire [2:0]  req_chan1,
   input  wire [1:0]  req_prio1,
   input  wire [15:0] chan_result_ptr,
   input  wire [3:0]  accum_en,
   input  wire [3:0]  wait_for_read,
   input  wire        comp_in,
   input  wire        rd_strobe,
   input  wire [1:0]  rd_sel,
   output wire        req_ack0,
   output wire        req_ack1,
   output reg  [2:0]  mux_sel,
   output reg         sample_en,
   output wire [9:0]  sar_trial,
   output reg         busy,
   output reg         sample,
   output reg  [1:0]  src_irq,
   output reg  [7:0]  chan_irq,
   output wire [3:0]  result_irq,
   output wire [10:0] rd_data,
   output wire [3:0]  unread
);

   reg  [2:0] state;
   reg  [8:0] phase_cnt;
   reg  [9:0] sar_code;
   reg  [9:0] trial_bit;
   reg  [9:0] conv_value;
   reg        cur_src;
   reg  [1:0] cur_target;
   reg        store_wr;
   wire       tick;
   wire       start;
   wire       blocked0;
   wire       blocked1;
   wire       ok0;
   wire       ok1;
   wire       pick1;
   wire [1:0] tgt0;
   wire [1:0] tgt1;
   wire [9:0] last_bit;
   wire [8:0] sample_len;
   wire       store_to0;
   wire       store_to1;
   wire       sync_last;
   wire       sample_last;
   wire       write_last;
   wire       conv_last;

   function [1:0] target_of;
      input [15:0] ptr;
      input [2:0]  chan;
      begin
         target_of = ptr[{chan, 1'b0} +: 2];
      end
   endfunction

   // Phase counters run from zero; the last period is len - 1
   function last_period;
      input [8:0] cnt;
      input [8:0] len;
      begin
         last_period = (cnt == len - 9'h001);
      end
   endfunction

   // Start also restarts the prescaler, so sync is one full period
   // phase timing counts prescaler pulses
   acc_prescaler u_prescaler (
      .core_clk           (core_clk),
      .rst                (rst),
      .analog_enable      (analog_enable),
      .restart            (start),
      .conv_clock_div_sel (conv_clock_div_sel),
      .tick               (tick)
   );

   // Store writes land one cycle after the channel interrupt
   // results go to shared registers
   acc_result_store u_results (
      .core_clk   (core_clk),
      .rst        (rst),
      .wr         (store_wr),
      .wr_sel     (cur_target),
      .wr_data    (conv_value),
      .accum_en   (accum_en),
      .rd_strobe  (rd_strobe),
      .rd_sel     (rd_sel),
      .rd_data    (rd_data),
      .unread     (unread),
      .result_irq (result_irq)
   );

   assign tgt0 = target_of(chan_result_ptr, req_chan0);
   assign tgt1 = target_of(chan_result_ptr, req_chan1);

   // A result on its way into the store already counts as unread, or a
   // waiting request could slip in during the cycle of the write itself
   assign store_to0 = store_wr & (cur_target == tgt0);
   assign store_to1 = store_wr & (cur_target == tgt1);

   // hold requests whose target is unread and has its wait_for_read bit set
   assign blocked0 = wait_for_read[tgt0] & (unread[tgt0] | store_to0);
   assign blocked1 = wait_for_read[tgt1] & (unread[tgt1] | store_to1);

   assign ok0 = req_pend0 & ~blocked0;
   assign ok1 = req_pend1 & ~blocked1;

   // higher priority wins, tie to source 0
   assign pick1 = ok1 & (~ok0 | (req_prio1 > req_prio0));

   // no start while analog part is off
   assign start = analog_enable & (state == `ACC_ST_IDLE) & (ok0 | ok1);

   // Acks last only the start cycle; sources drop their request after it
   assign req_ack0 = start & ~pick1;
   assign req_ack1 = start & pick1;

   // Lowest bit weight tried: bit 2 for 8-bit, bit 0 for 10-bit
   // eight or ten bit approximation
   assign last_bit = res_8bit ? 10'h004 : 10'h001;

   // sample length common to all channels
   assign sample_len = `ACC_SAMPLE_BASE + {1'b0, sample_time_ext};

   // Phase ends, decoded once for the sequencer below
   assign sync_last   = last_period(phase_cnt, `ACC_SYNC_TICKS);
   assign sample_last = last_period(phase_cnt, sample_len);
   assign write_last  = last_period(phase_cnt, `ACC_WRITE_TICKS);
   assign conv_last   = (trial_bit == last_bit);

   // The analog stage compares against the kept bits plus the trial bit
   assign sar_trial = sar_code | trial_bit;

   // control, flags and interrupts on core_clk
   always @(posedge core_clk) begin
      if (rst) begin
         state      <= `ACC_ST_IDLE;
         phase_cnt  <= 9'h000;
         sar_code   <= 10'h000;
         trial_bit  <= 10'h000;
         conv_value <= 10'h000;
         cur_src    <= 1'b0;
         cur_target <= 2'h0;
         mux_sel    <= 3'h0;
         sample_en  <= 1'b0;
         busy       <= 1'b0;
         sample     <= 1'b0;
         src_irq    <= 2'h0;
         chan_irq   <= 8'h00;
         store_wr   <= 1'b0;
      end else begin
         src_irq  <= 2'h0;
         chan_irq <= 8'h00;
         store_wr <= 1'b0;
         if (!analog_enable && state != `ACC_ST_IDLE) begin
            // Disabling mid-conversion abandons it; no result is written
            // and the trial code returns to zero with the rest
            state     <= `ACC_ST_IDLE;
            busy      <= 1'b0;
            sample    <= 1'b0;
            sample_en <= 1'b0;
            trial_bit <= 10'h000;
            sar_code  <= 10'h000;
         end else begin
            case (state)
               `ACC_ST_IDLE: begin
                  if (start) begin
                     // busy and sample set on trigger
                     busy       <= 1'b1;
                     sample     <= 1'b1;
                     cur_src    <= pick1;
                     mux_sel    <= pick1 ? req_chan1 : req_chan0;
                     cur_target <= pick1 ? tgt1 : tgt0;
                     phase_cnt  <= 9'h000;
                     state      <= `ACC_ST_SYNC;
                  end
               end
               `ACC_ST_SYNC: begin
                  if (tick) begin
                     if (sync_last) begin
                        phase_cnt <= 9'h000;
                        sample_en <= 1'b1;
                        state     <= `ACC_ST_SAMPLE;
                     end else begin
                        phase_cnt <= phase_cnt + 9'h001;
                     end
                  end
               end
               `ACC_ST_SAMPLE: begin
                  if (tick) begin
                     // sample ends after 2 + ext periods
                     if (sample_last) begin
                        phase_cnt <= 9'h000;
                        sample_en <= 1'b0;
                        sample    <= 1'b0;
                        sar_code  <= 10'h000;
                        trial_bit <= 10'h200;
                        state     <= `ACC_ST_CONV;
                     end else begin
                        phase_cnt <= phase_cnt + 9'h001;
                     end
                  end
               end
               `ACC_ST_CONV: begin
                  if (tick) begin
                     // keep trial bit if comparator agrees
                     if (comp_in) begin
                        sar_code <= sar_code | trial_bit;
                     end
                     if (conv_last) begin
                        // n periods here give 1 + r(3+n+ext)
                        if (res_8bit) begin
                           conv_value <= {2'h0,
                              (sar_code[9:2] | {7'h00, comp_in})};
                        end else begin
                           conv_value <= sar_code | {9'h000, comp_in};
                        end
                        trial_bit <= 10'h000;
                        // Idle keeps the trial code at zero
                        sar_code  <= 10'h000;
                        busy      <= 1'b0;
                        src_irq   <= cur_src ? 2'h2 : 2'h1;
                        phase_cnt <= 9'h000;
                        state     <= `ACC_ST_WRITE;
                     end else begin
                        trial_bit <= trial_bit >> 1;
                     end
                  end
               end
               `ACC_ST_WRITE: begin
                  if (tick) begin
                     if (write_last) begin
                        chan_irq[mux_sel] <= 1'b1;
                        store_wr <= 1'b1;
                        state    <= `ACC_ST_IDLE;
                     end else begin
                        phase_cnt <= phase_cnt + 9'h001;
                     end
                  end
               end
               default: begin
                  state <= `ACC_ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* File: tb/acc_analog_model.sv */
// Analog converter stage model: holds a channel-dependent level.
// Assumes sar_trial is the code under test during conversion.
`timescale 1ns/1ns
`default_nettype none
module acc_analog_model (
   input  wire logic [2:0] mux_sel,
   input  wire logic       core_clk,
   input  wire logic       sample_en,
   input  wire logic [9:0] sar_trial,
   output var  logic       comp_in
);
   logic [9:0] held;
   initial held = 10'h000;
   // Level tracks the channel, so a wrong channel shows in the result
   always @(posedge core_clk) begin
      if (sample_en)
         held <= {mux_sel, 7'h55};
   end
   assign comp_in = (held >= sar_trial);
endmodule
`default_nettype wire

/* File: tb/acc_conv_ctrl_monitor.sv */
// Port checker for the conversion sequencer.
// Assumes timing inputs stay fixed while a conversion runs.
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl_monitor (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       analog_enable,
   input wire logic [1:0] conv_clock_div_sel,
   input wire logic [7:0] sample_time_ext,
   input wire logic       res_8bit,
   input wire logic       req_ack0,
   input wire logic       req_ack1,
   input wire logic [9:0] sar_trial,
   input wire logic       busy,
   input wire logic       sample,
   input wire logic [1:0] src_irq,
   input wire logic [7:0] chan_irq,
   input wire logic [3:0] result_irq
);
   logic [15:0] cnt;
   int          r;
   int          len;
   wire         ack = req_ack0 | req_ack1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   assign r = (conv_clock_div_sel == 2'h3) ? 32 : int'(conv_clock_div_sel) + 2;
   assign len = 1 + r * (3 + int'(sample_time_ext) + (res_8bit ? 8 : 10));
   // Length from the trigger cycle on, read in the first idle cycle
   always_ff @(posedge core_clk) begin
      if (rst || (!busy && !ack))
         cnt <= 16'h0000;
      else
         cnt <= cnt + 16'h0001;
   end
   // Aborts drop analog_enable, so they never match
   sequence done_s;
      $fell(busy) && analog_enable && !$past(rst);
   endsequence
   AST_START: assert property (ack |=> busy && sample)
      else $error("flags not set at start");
   AST_IDLE: assert property (ack |-> !busy && analog_enable)
      else $error("start while busy or off");
   AST_ONE: assert property (!(req_ack0 && req_ack1))
      else $error("two sources taken");
   AST_SMP_END: assert property ($fell(sample) && analog_enable |-> busy)
      else $error("busy dropped with sample");
   AST_SRC: assert property (done_s |-> $onehot(src_irq))
      else $error("no source irq at end");
   AST_SRC_END: assert property (src_irq != 2'h0 |-> $fell(busy))
      else $error("source irq off end");
   AST_LEN: assert property (done_s |-> cnt == len[15:0])
      else $error("conversion length");
   AST_CHAN: assert property (done_s ##0 conv_clock_div_sel == 2'h1
      |-> ##9 $onehot(chan_irq))
      else $error("channel irq delay");
   AST_RES: assert property (chan_irq != 8'h00 |=> $onehot(result_irq))
      else $error("result irq missing");
   AST_TRIAL: assert property (!busy |-> sar_trial == 10'h000)
      else $error("trial code while idle");
   CV_8BIT: cover property (done_s ##0 res_8bit);
   CV_SRC1: cover property (req_ack1);
   CV_RES: cover property (result_irq != 4'h0);
endmodule
bind acc_conv_ctrl acc_conv_ctrl_monitor u_mon (
   .core_clk(core_clk), .rst(rst), .analog_enable(analog_enable),
   .conv_clock_div_sel(conv_clock_div_sel), .res_8bit(res_8bit),
   .sample_time_ext(sample_time_ext), .req_ack0(req_ack0),
   .req_ack1(req_ack1), .sar_trial(sar_trial), .busy(busy),
   .sample(sample), .src_irq(src_irq), .chan_irq(chan_irq),
   .result_irq(result_irq)
);
`default_nettype wire

/* File: tb/acc_conv_ctrl_tb.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the analog stage model and channel c stored in register c%4.
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl_tb;
   logic        core_clk, rst, analog_enable, res_8bit, rd_strobe, comp_in;
   logic        sample_en, busy, sample;
   logic [1:0]  conv_clock_div_sel, rd_sel, src_irq, pend, ack;
   logic [1:0]  prio [2];
   logic [2:0]  chan [2];
   logic [2:0]  mux_sel;
   logic [7:0]  sample_time_ext, chan_irq;
   logic [3:0]  accum_en, wait_for_read, result_irq, unread;
   logic [9:0]  sar_trial;
   logic [10:0] rd_data;
   int          miscompares, samples_checked;

   acc_conv_ctrl DUT (
      .core_clk(core_clk), .rst(rst), .analog_enable(analog_enable),
      .conv_clock_div_sel(conv_clock_div_sel), .res_8bit(res_8bit),
      .sample_time_ext(sample_time_ext), .req_pend0(pend[0]),
      .req_chan0(chan[0]), .req_prio0(prio[0]), .req_pend1(pend[1]),
      .req_chan1(chan[1]), .req_prio1(prio[1]),
      .chan_result_ptr(16'he4e4), .accum_en(accum_en),
      .wait_for_read(wait_for_read), .comp_in(comp_in),
      .rd_strobe(rd_strobe), .rd_sel(rd_sel), .req_ack0(ack[0]),
      .req_ack1(ack[1]), .mux_sel(mux_sel), .sample_en(sample_en),
      .sar_trial(sar_trial), .busy(busy), .sample(sample),
      .src_irq(src_irq), .chan_irq(chan_irq), .result_irq(result_irq),
      .rd_data(rd_data), .unread(unread)
   );
   acc_analog_model u_ana (
      .mux_sel(mux_sel), .core_clk(core_clk), .sample_en(sample_en),
      .sar_trial(sar_trial), .comp_in(comp_in)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   function automatic logic [10:0] lvl(input logic [2:0] c);
      return res_8bit ? {3'h0, c, 5'h15} : {1'h0, c, 7'h55};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic request(input bit s, input logic [2:0] ch);
      int n;
      n = 0;
      pend[s] = 1'b1;
      chan[s] = ch;
      #1;
      while (ack[s] !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         #1;
         n++;
      end
      @(negedge core_clk);
      pend[s] = 1'b0;
   endtask

   task automatic finish(input bit s, input logic [2:0] ch);
      int n, k, r, want;
      r = (conv_clock_div_sel == 2'h3) ? 32 : int'(conv_clock_div_sel) + 2;
      want = 1 + r * (3 + sample_time_ext + (res_8bit ? 8 : 10));
      // The trigger cycle before busy rises counts towards the total
      n = 1;
      k = 0;
      while (busy === 1'b1 && n < 20000) begin
         n++;
         @(negedge core_clk);
      end
      check(16'(n), 16'(want));
      check(16'(src_irq), 16'(1 << s));
      while (chan_irq === 8'h00 && k < 2000) begin
         k++;
         @(negedge core_clk);
      end
      check(16'(k), 16'(3 * r));
      check(16'(chan_irq), 16'(1 << ch));
      @(negedge core_clk);
      check(16'(result_irq), 16'(1 << ch[1:0]));
      check(16'(unread[ch[1:0]]), 16'h0001);
   endtask

   task automatic readchk(input logic [1:0] rg, input logic [10:0] exp);
      rd_strobe = 1'b1;
      rd_sel = rg;
      @(negedge core_clk);
      rd_strobe = 1'b0;
      check(16'(rd_data), 16'(exp));
      check(16'(unread[rg]), 16'h0000);
   endtask

   task automatic convert(input bit s, input logic [2:0] ch);
      request(s, ch);
      finish(s, ch);
      readchk(ch[1:0], lvl(ch));
   endtask

   task automatic race(input bit w, input logic [2:0] c0,
                       input logic [2:0] c1);
      chan[0] = c0;
      chan[1] = c1;
      pend = 2'h3;
      #1;
      check(16'(ack), 16'(1 << w));
      @(negedge core_clk);
      pend = 2'h0;
      finish(w, w ? c1 : c0);
      readchk(w ? c1[1:0] : c0[1:0], lvl(w ? c1 : c0));
   endtask

   // Only the /32 code keeps the analog clock legal at this rate
   // faster codes test counting only
   task automatic t_divider();
      for (int i = 0; i < 4; i++) begin
         conv_clock_div_sel = 2'(i);
         sample_time_ext = 8'(i);
         res_8bit = (i == 2);
         convert(0, 3'(2 * i + 1));
      end
      conv_clock_div_sel = 2'h1;
      sample_time_ext = 8'h00;
      res_8bit = 1'b0;
   endtask

   task automatic t_priority();
      prio[1] = 2'h2;
      race(1, 3'h4, 3'h2);
      prio[0] = 2'h3;
      race(0, 3'h5, 3'h6);
      prio[1] = 2'h3;
      race(0, 3'h0, 3'h7);
   endtask

   task automatic t_wait();
      wait_for_read = 4'h2;
      request(0, 3'h1);
      finish(0, 3'h1);
      pend[0] = 1'b1;
      repeat (20) @(negedge core_clk);
      check(16'({busy, ack[0]}), 16'h0000);
      readchk(2'h1, lvl(3'h1));
      convert(0, 3'h1);
      wait_for_read = 4'h0;
   endtask

   task automatic t_accum();
      accum_en = 4'h8;
      request(0, 3'h3);
      finish(0, 3'h3);
      request(1, 3'h3);
      finish(1, 3'h3);
      readchk(2'h3, 11'(2 * lvl(3'h3)));
      convert(0, 3'h3);
      accum_en = 4'h0;
   endtask

   task automatic t_disable();
      request(0, 3'h4);
      repeat (10) @(negedge core_clk);
      analog_enable = 1'b0;
      pend[0] = 1'b1;
      @(negedge core_clk);
      check(16'({busy, sample, src_irq}), 16'h0000);
      repeat (30) @(negedge core_clk);
      check(16'({busy, ack[0], result_irq}), 16'h0000);
      analog_enable = 1'b1;
      convert(0, 3'h4);
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      analog_enable = 1'b1;
      res_8bit = 1'b0;
      rd_strobe = 1'b0;
      rd_sel = 2'h0;
      pend = 2'h0;
      prio[0] = 2'h0;
      prio[1] = 2'h0;
      chan[0] = 3'h0;
      chan[1] = 3'h0;
      conv_clock_div_sel = 2'h1;
      sample_time_ext = 8'h00;
      accum_en = 4'h0;
      wait_for_read = 4'h0;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      t_divider();
      t_priority();
      t_wait();
      t_accum();
      t_disable();
      give_verdict();
   end
endmodule
`default_nettype wire
